// file: dmc_pkg.sv
// Package: constants, fields and types of the converter configuration loader
package dmc_pkg;
    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [3:0] REG_MODE = 4'h2;
    localparam logic [3:0] REG_VOLMIX = 4'h3;
    localparam logic [3:0] REG_MUTE = 4'h4;
    localparam logic [3:0] REG_VOLA = 4'h5;
    localparam logic [3:0] REG_VOLB = 4'h6;
    localparam logic [3:0] REG_FILT = 4'h7;
    localparam logic [3:0] REG_MISC = 4'h8;
    localparam logic [3:0] REG_MISC2 = 4'h9;
    localparam int NUM_REGS = 16;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_VOLMIX = 8'h09;
    localparam logic [7:0] RST_MUTE = 8'hC0;
    localparam logic [7:0] RST_VOL = 8'h00;
    localparam logic [7:0] RST_FILT = 8'hB0;
    localparam logic [7:0] RST_MISC = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PTR = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int PTR_POINTER_AUTO_INCREMENT_BIT = 7;
    localparam int MISC_PDN_BIT = 7;
    localparam int MISC_CTRL_PORT_ENABLE_BIT = 6;
    localparam int MODE_SRC_BIT = 7;
    localparam int MODE_FMT_LSB = 4;
    localparam int MODE_DEM_LSB = 2;
    localparam int MUTE_AUTO_BIT = 6;
    localparam int FILTER_SELECT_BIT = 2;
    localparam int FILT_DIR_BIT = 0;
    localparam int MISC2_STATIC_BIT = 3;
    localparam int MISC2_INVALID_BIT = 2;
    localparam int MISC2_PMCLK_BIT = 1;
    localparam int MISC2_PMEN_BIT = 0;
    localparam logic [7:0] PTR_WMASK = 8'h8F;
    // ****************************************
    // Modes and formats
    // ****************************************
    localparam logic [1:0] SPEED_SINGLE = 2'h0;
    localparam logic [1:0] SPEED_DOUBLE = 2'h1;
    localparam logic [1:0] SPEED_QUAD = 2'h2;
    localparam logic [1:0] SPEED_STREAM = 2'h3;
    localparam logic [2:0] FMT_LJ24 = 3'h0;
    localparam logic [2:0] FMT_I2S24 = 3'h1;
    localparam logic [2:0] FMT_RJ16 = 3'h2;
    localparam logic [2:0] FMT_RJ24 = 3'h3;
    localparam logic [1:0] DEM_NONE = 2'h0;
    localparam logic [1:0] DEM_44K1 = 2'h2;
    localparam logic [7:0] OSR_SINGLE = 8'h80;
    localparam logic [7:0] OSR_DOUBLE = 8'h40;
    localparam logic [7:0] OSR_QUAD = 8'h20;
    // Volume in eighth-dB steps of attenuation; mute level is full scale down
    localparam logic [10:0] VOL_MUTE_EIGHTHS = 11'h400;
    localparam int PWRUP_WAIT_CYCLES = 262144;
    typedef enum logic [1:0] {
        DMC_RESET = 2'b00,
        DMC_WAIT = 2'b01,
        DMC_STRAP_RUN = 2'b11,
        DMC_PORT_RUN = 2'b10
    } dmc_state_t;
endpackage

// file: dmc_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
module dmc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: dmc_ramp.sv
// Soft volume ramp: eighth-dB step per frame, from mute to 0 dB
module dmc_ramp (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic frame_tick,
    output logic [10:0] atten_eighths,
    output logic ramp_done
);
    logic [10:0] atten_reg;
    logic [10:0] atten_next;
    assign atten_next = restart ? dmc_pkg::VOL_MUTE_EIGHTHS :
        (frame_tick && atten_reg != 11'h000) ? atten_reg - 11'h001 : atten_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            atten_reg <= dmc_pkg::VOL_MUTE_EIGHTHS;
        end else begin
            atten_reg <= atten_next;
        end
    end
    assign atten_eighths = atten_reg;
    assign ramp_done = (atten_reg == 11'h000);
endmodule

// file: dmc_config.sv
// Top: strap decode, power-up timing, control registers and pointer
// What this block does
// - Straps fmt_sel1:0 pick LJ24, I2S24, RJ16 or RJ24.
// - Straps speed_sel1:0 pick single, single+44.1k de-emphasis, double, quad.
// - Strap mode forces auto-mute, auto mute polarity and fast filter.
// - Strap mode ramps volume mute to 0 dB, eighth dB per frame.
// - Strap mode offers no stream, RJ18/20, clock divide, slow filter, volume.
// - Reset low returns all control registers to defaults.
// - After reset, stay low power, strap start after 2^18 clocks.
// - Setting ctrl_port_enable aborts strap start and defaults registers.
// - Host loads settings with power_down_bit set; clearing it powers up.
// - Missed enable starts strap mode; host keeps audio input at zero.
// - Port mode takes speed and format from register 2.
// - Register 4 mute polarity field overrides detected polarity.
// - Register 7 filter_select picks fast or slow filter.
// - In stream mode, format gives rate; pin select picks inputs.
// - bitstream_direct_path picks processed or direct stream path.
// - phase_mod_enable expects phase-modulated input; clock select chosen.
// - Stream fixes detect bad data; mute follows stream_automute.
// - One volume setting scales both PCM and stream outputs.
// - Port transfers are asynchronous to audio; host keeps pins static.
// - Pointer bit 7 selects fixed or auto-incrementing pointer.
// - Pointer bits 3:0 select the register, reset to zero.
// - Mute pins float in reset; level at release sets polarity.
// - Oversampling 128x single, 64x double, 32x quad.
module dmc_config #(
    parameter int PWRUP_WAIT = dmc_pkg::PWRUP_WAIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fmt_sel0_pin,
    input wire logic fmt_sel1_pin,
    input wire logic speed_sel0_pin,
    input wire logic speed_sel1_pin,
    input wire logic frame_clk,
    input wire logic [1:0] mute_drive_in,
    input wire logic mute_request,
    input wire logic stream_error,
    input wire logic byte_valid,
    input wire logic byte_first,
    input wire logic byte_read,
    input wire logic [7:0] byte_wdata,
    output logic [7:0] byte_rdata,
    output logic [1:0] mute_drive_out,
    output logic [1:0] mute_drive_oe,
    output logic powered_up,
    output logic port_mode,
    output logic [1:0] speed_mode,
    output logic [2:0] audio_format,
    output logic [1:0] deemph_sel,
    output logic [7:0] osr_ratio,
    output logic slow_filter,
    output logic bitstream_mode,
    output logic bitstream_pin_sel,
    output logic bitstream_direct,
    output logic phase_mod_en,
    output logic phase_mod_clk,
    output logic stream_fix_en,
    output logic [10:0] volume_atten
);
    // ****************************************
    // Reset and input synchronisers
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    logic [3:0] straps_sync;
    logic frame_sync;
    logic [1:0] mute_sense_sync;
    // Raw reset: synced levels are settled by the first cycle after release
    dmc_sync2 #(.WIDTH(7)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({speed_sel1_pin, speed_sel0_pin, fmt_sel1_pin, fmt_sel0_pin,
            frame_clk, mute_drive_in}),
        .sync_out({straps_sync, frame_sync, mute_sense_sync})
    );

    logic frame_prev_reg;
    logic frame_tick;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            frame_prev_reg <= 1'b0;
        end else begin
            frame_prev_reg <= frame_sync;
        end
    end
    assign frame_tick = frame_sync && !frame_prev_reg;

    // ****************************************
    // Register file and pointer
    // ****************************************
    logic [7:0] regs_reg [dmc_pkg::NUM_REGS];
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic [3:0] ptr_idx;
    logic ptr_pointer_auto_increment;
    logic data_wr;
    logic data_rd;
    logic ctrl_port_enable_set;
    logic [7:0] misc_reg;
    assign ptr_idx = ptr_reg[3:0];
    assign ptr_pointer_auto_increment = ptr_reg[dmc_pkg::PTR_POINTER_AUTO_INCREMENT_BIT];
    assign data_wr = byte_valid && !byte_read && !byte_first;
    assign data_rd = byte_valid && byte_read;
    assign misc_reg = regs_reg[dmc_pkg::REG_MISC];
    assign ctrl_port_enable_set = data_wr && ptr_idx == dmc_pkg::REG_MISC &&
        byte_wdata[dmc_pkg::MISC_CTRL_PORT_ENABLE_BIT] && !misc_reg[dmc_pkg::MISC_CTRL_PORT_ENABLE_BIT];

    // First byte of a write is the pointer; reserved bits dropped
    assign ptr_next = (byte_valid && byte_first && !byte_read) ?
        (byte_wdata & dmc_pkg::PTR_WMASK) :
        ((data_wr || data_rd) && ptr_pointer_auto_increment) ?
        {ptr_reg[7:4], ptr_idx + 4'h1} : ptr_reg;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ptr_reg <= dmc_pkg::RST_PTR;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    function automatic logic [7:0] reg_default(input logic [3:0] idx);
        logic [7:0] v;
        v = dmc_pkg::RST_ZERO;
        case (idx)
            dmc_pkg::REG_MODE: v = dmc_pkg::RST_MODE;
            dmc_pkg::REG_VOLMIX: v = dmc_pkg::RST_VOLMIX;
            dmc_pkg::REG_MUTE: v = dmc_pkg::RST_MUTE;
            dmc_pkg::REG_VOLA: v = dmc_pkg::RST_VOL;
            dmc_pkg::REG_VOLB: v = dmc_pkg::RST_VOL;
            dmc_pkg::REG_FILT: v = dmc_pkg::RST_FILT;
            dmc_pkg::REG_MISC: v = dmc_pkg::RST_MISC;
            default: v = dmc_pkg::RST_ZERO;
        endcase
        return v;
    endfunction

    // Enable write defaults every other register and stores itself in the same cycle
    for (genvar g = 0; g < dmc_pkg::NUM_REGS; g++) begin : g_regs
        logic [7:0] reg_next;
        assign reg_next = (data_wr && ptr_idx == 4'(g)) ? byte_wdata :
            ctrl_port_enable_set ? reg_default(4'(g)) : regs_reg[g];
        always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                regs_reg[g] <= reg_default(4'(g));
            end else begin
                regs_reg[g] <= reg_next;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            byte_rdata <= 8'h00;
        end else if (data_rd) begin
            byte_rdata <= regs_reg[ptr_idx];
        end
    end

    // ****************************************
    // Power-up sequencing
    // ****************************************
    dmc_pkg::dmc_state_t state_reg;
    dmc_pkg::dmc_state_t state_next;
    logic [18:0] wait_cnt_reg;
    logic wait_done;
    logic ctrl_port_enable;
    logic power_down_bit;
    assign ctrl_port_enable = misc_reg[dmc_pkg::MISC_CTRL_PORT_ENABLE_BIT];
    assign power_down_bit = misc_reg[dmc_pkg::MISC_PDN_BIT];
    assign wait_done = (wait_cnt_reg >= 19'(PWRUP_WAIT - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dmc_pkg::DMC_RESET: state_next = dmc_pkg::DMC_WAIT;
            dmc_pkg::DMC_WAIT: begin
                if (ctrl_port_enable || ctrl_port_enable_set) begin
                    state_next = dmc_pkg::DMC_PORT_RUN;
                end else if (wait_done) begin
                    state_next = dmc_pkg::DMC_STRAP_RUN;
                end
            end
            dmc_pkg::DMC_STRAP_RUN: begin
                if (ctrl_port_enable) begin
                    state_next = dmc_pkg::DMC_PORT_RUN;
                end
            end
            dmc_pkg::DMC_PORT_RUN: state_next = dmc_pkg::DMC_PORT_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= dmc_pkg::DMC_RESET;
            wait_cnt_reg <= 19'h00000;
        end else begin
            state_reg <= state_next;
            if (state_reg == dmc_pkg::DMC_WAIT && !wait_done) begin
                wait_cnt_reg <= wait_cnt_reg + 19'h00001;
            end
        end
    end

    logic strap_on;
    logic port_on;
    assign strap_on = (state_reg == dmc_pkg::DMC_STRAP_RUN);
    assign port_on = (state_reg == dmc_pkg::DMC_PORT_RUN) && !power_down_bit;
    assign port_mode = (state_reg == dmc_pkg::DMC_PORT_RUN);
    assign powered_up = strap_on || port_on;

    // ****************************************
    // Mute polarity capture at reset release
    // ****************************************
    logic [1:0] mute_pol_reg;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mute_pol_reg <= 2'b00;
        end else if (state_reg == dmc_pkg::DMC_RESET) begin
            mute_pol_reg <= mute_sense_sync;
        end
    end

    // ****************************************
    // Mode decode
    // ****************************************
    logic [7:0] mode_reg;
    logic [7:0] filt_reg;
    logic [7:0] mute_cfg;
    logic [7:0] misc2_reg;
    logic [1:0] strap_speed;
    logic [2:0] strap_fmt;
    logic [1:0] strap_dem;
    assign mode_reg = regs_reg[dmc_pkg::REG_MODE];
    assign filt_reg = regs_reg[dmc_pkg::REG_FILT];
    assign mute_cfg = regs_reg[dmc_pkg::REG_MUTE];
    assign misc2_reg = regs_reg[dmc_pkg::REG_MISC2];

    assign strap_fmt = straps_sync[1] ?
        (straps_sync[0] ? dmc_pkg::FMT_RJ24 : dmc_pkg::FMT_RJ16) :
        (straps_sync[0] ? dmc_pkg::FMT_I2S24 : dmc_pkg::FMT_LJ24);
    assign strap_speed = straps_sync[3] ?
        (straps_sync[2] ? dmc_pkg::SPEED_QUAD : dmc_pkg::SPEED_DOUBLE) :
        dmc_pkg::SPEED_SINGLE;
    assign strap_dem = (straps_sync[3:2] == 2'b01) ?
        dmc_pkg::DEM_44K1 : dmc_pkg::DEM_NONE;

    logic [1:0] speed_cur;
    assign speed_cur = port_mode ? mode_reg[1:0] : strap_speed;
    logic [1:0] speed_q;
    logic [2:0] fmt_q;
    logic [1:0] dem_q;
    logic [7:0] osr_q;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            speed_q <= dmc_pkg::SPEED_SINGLE;
            fmt_q <= dmc_pkg::FMT_LJ24;
            dem_q <= dmc_pkg::DEM_NONE;
            osr_q <= dmc_pkg::OSR_SINGLE;
        end else begin
            speed_q <= speed_cur;
            fmt_q <= port_mode ?
                mode_reg[dmc_pkg::MODE_FMT_LSB +: 3] : strap_fmt;
            dem_q <= port_mode ? mode_reg[dmc_pkg::MODE_DEM_LSB +: 2] : strap_dem;
            osr_q <= (speed_cur == dmc_pkg::SPEED_QUAD) ? dmc_pkg::OSR_QUAD :
                (speed_cur == dmc_pkg::SPEED_DOUBLE) ? dmc_pkg::OSR_DOUBLE :
                dmc_pkg::OSR_SINGLE;
        end
    end
    assign speed_mode = speed_q;
    assign audio_format = fmt_q;
    assign deemph_sel = dem_q;
    assign osr_ratio = osr_q;

    // Stream features only reachable in port mode
    logic in_stream;
    assign in_stream = port_mode && speed_q == dmc_pkg::SPEED_STREAM;
    assign bitstream_mode = in_stream;
    assign bitstream_pin_sel = in_stream && mode_reg[dmc_pkg::MODE_SRC_BIT];
    assign bitstream_direct = in_stream && filt_reg[dmc_pkg::FILT_DIR_BIT];
    assign phase_mod_en = in_stream && misc2_reg[dmc_pkg::MISC2_PMEN_BIT];
    assign phase_mod_clk = in_stream && misc2_reg[dmc_pkg::MISC2_PMCLK_BIT];
    assign stream_fix_en = in_stream && (misc2_reg[dmc_pkg::MISC2_STATIC_BIT] ||
        misc2_reg[dmc_pkg::MISC2_INVALID_BIT]);
    assign slow_filter = port_mode && filt_reg[dmc_pkg::FILTER_SELECT_BIT];

    // ****************************************
    // Volume ramp and mute drive
    // ****************************************
    logic restart_ramp;
    assign restart_ramp = !powered_up || (speed_cur != speed_q);
    dmc_ramp u_ramp (
        .core_clk(core_clk),
        .rst_n(rst_sync_n),
        .restart(restart_ramp),
        .frame_tick(frame_tick),
        .atten_eighths(volume_atten),
        .ramp_done()
    );

    logic mute_act;
    logic [1:0] pol_use;
    assign mute_act = !powered_up || mute_request ||
        (stream_fix_en && stream_error && mute_cfg[dmc_pkg::MUTE_AUTO_BIT]);
    assign pol_use = (port_mode && mute_cfg[1:0] != 2'b00) ?
        {mute_cfg[1], mute_cfg[1]} : mute_pol_reg;
    logic [1:0] mute_q;
    logic [1:0] mute_oe_q;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mute_q <= 2'b00;
            mute_oe_q <= 2'b00;
        end else begin
            mute_q <= mute_act ? pol_use : ~pol_use;
            mute_oe_q <= (state_reg != dmc_pkg::DMC_RESET) ? 2'b11 : 2'b00;
        end
    end
    assign mute_drive_out = mute_q;
    assign mute_drive_oe = mute_oe_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_strap_wait;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == dmc_pkg::DMC_WAIT && !ctrl_port_enable && !ctrl_port_enable_set && !wait_done)
            |=> state_reg != dmc_pkg::DMC_STRAP_RUN;
    endproperty
    a_strap_wait: assert property (p_strap_wait) else $error("early start");
    property p_ctrl_port_enable_abort;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (state_reg == dmc_pkg::DMC_WAIT && ctrl_port_enable_set) |=> port_mode;
    endproperty
    a_ctrl_port_enable_abort: assert property (p_ctrl_port_enable_abort) else $error("no abort");
    property p_pdn_hold;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (port_mode && power_down_bit) |-> !powered_up;
    endproperty
    a_pdn_hold: assert property (p_pdn_hold) else $error("powered with pdn");
    property p_ptr_fixed;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (data_wr && !ptr_pointer_auto_increment) |=> ptr_idx == $past(ptr_idx);
    endproperty
    a_ptr_fixed: assert property (p_ptr_fixed) else $error("pointer moved");
    property p_ptr_pointer_auto_increment;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (data_wr && ptr_pointer_auto_increment) |=> ptr_idx == $past(ptr_idx) + 4'h1;
    endproperty
    a_ptr_pointer_auto_increment: assert property (p_ptr_pointer_auto_increment) else $error("no increment");
    property p_ptr_rsv;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ptr_reg[6:4] == 3'b000;
    endproperty
    a_ptr_rsv: assert property (p_ptr_rsv) else $error("reserved set");
    property p_strap_fast;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !port_mode |-> !slow_filter && !bitstream_mode;
    endproperty
    a_strap_fast: assert property (p_strap_fast) else $error("strap feature");
    property p_osr;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (speed_q == dmc_pkg::SPEED_DOUBLE) |-> osr_ratio == dmc_pkg::OSR_DOUBLE;
    endproperty
    a_osr: assert property (p_osr) else $error("ratio wrong");
    property p_strap_fmt;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!port_mode ##1 !port_mode) |-> audio_format == $past(strap_fmt);
    endproperty
    a_strap_fmt: assert property (p_strap_fmt) else $error("format decode");
endmodule

// file: dmc_host_model.sv
// Host model: byte-level control port master for the configuration loader
module dmc_host_model (
    input wire logic core_clk,
    input wire logic [7:0] byte_rdata,
    output logic byte_valid,
    output logic byte_first,
    output logic byte_read,
    output logic [7:0] byte_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        byte_valid = 1'b0;
        byte_first = 1'b0;
        byte_read = 1'b0;
        byte_wdata = 8'h00;
    end
    task automatic xfer(input logic first, input logic rd, input logic [7:0] data,
                        output logic [7:0] rdata);
        @(negedge core_clk);
        byte_valid = 1'b1;
        byte_first = first;
        byte_read = rd;
        byte_wdata = data;
        @(posedge core_clk);
        @(negedge core_clk);
        byte_valid = 1'b0;
        byte_first = 1'b0;
        byte_read = 1'b0;
        byte_wdata = ~data;
        @(posedge core_clk);
        #1;
        rdata = byte_rdata;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        logic [7:0] unused;
        xfer(1'b1, 1'b0, ptr, unused);
        xfer(1'b0, 1'b0, data, unused);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
        logic [7:0] unused;
        xfer(1'b1, 1'b0, ptr, unused);
        xfer(1'b0, 1'b1, 8'h00, data);
    endtask
endmodule

// file: dac_mode_config_power_up_tb_top.sv
// Testbench top: strap decode, power-up timing and control registers
module dac_mode_config_power_up_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAIT_SIM = 64;
    logic core_clk, rst_n, frame_clk, byte_valid, byte_first, byte_read;
    logic [3:0] straps;
    logic [7:0] byte_wdata, byte_rdata, rd_val, osr_ratio;
    logic [1:0] mute_drive_out, mute_drive_oe, speed_mode, deemph_sel;
    logic powered_up, port_mode, slow_filter, bitstream_mode, phase_mod_en;
    logic bitstream_pin_sel, bitstream_direct, phase_mod_clk, stream_fix_en;
    logic [2:0] audio_format;
    logic [10:0] volume_atten;
    wire logic [1:0] mute_pins;
    int num_errors = 0;
    int compares = 0;
    // Pulled-up mute pins unless driven
    assign mute_pins = (mute_drive_oe & mute_drive_out) | ~mute_drive_oe;
    dmc_config #(.PWRUP_WAIT(WAIT_SIM)) i_dmc_config (.core_clk(core_clk), .rst_n(rst_n),
        .fmt_sel0_pin(straps[0]), .fmt_sel1_pin(straps[1]), .speed_sel0_pin(straps[2]),
        .speed_sel1_pin(straps[3]), .frame_clk(frame_clk), .mute_drive_in(mute_pins),
        .mute_request(1'b0), .stream_error(1'b0), .byte_valid(byte_valid),
        .byte_first(byte_first), .byte_read(byte_read), .byte_wdata(byte_wdata),
        .byte_rdata(byte_rdata), .mute_drive_out(mute_drive_out),
        .mute_drive_oe(mute_drive_oe), .powered_up(powered_up), .port_mode(port_mode),
        .speed_mode(speed_mode), .audio_format(audio_format), .deemph_sel(deemph_sel),
        .osr_ratio(osr_ratio), .slow_filter(slow_filter), .bitstream_mode(bitstream_mode),
        .bitstream_pin_sel(bitstream_pin_sel), .bitstream_direct(bitstream_direct),
        .phase_mod_en(phase_mod_en), .phase_mod_clk(phase_mod_clk),
        .stream_fix_en(stream_fix_en), .volume_atten(volume_atten));
    dmc_host_model i_dmc_host_model (.core_clk(core_clk), .byte_rdata(byte_rdata),
        .byte_valid(byte_valid), .byte_first(byte_first), .byte_read(byte_read),
        .byte_wdata(byte_wdata));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(volume_atten, 16'h0400);
        chk(mute_drive_oe, 16'h0000);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(mute_drive_oe, 16'h0003);
        chk(mute_drive_out, 16'h0003);
    endtask
    task automatic wait_power();
        int n;
        n = 0;
        chk(powered_up, 16'h0000);
        while (powered_up !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            end_sim();
        end else begin
            chk(16'(n > WAIT_SIM - 16 && n < WAIT_SIM + 16), 16'h0001);
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        frame_clk = 1'b0;
        straps = 4'h0;
        for (int i = 0; i < 4; i++) begin
            straps = {i[1:0], i[1:0]};
            do_reset();
            wait_power();
            repeat (4) @(negedge core_clk);
            chk(port_mode, 16'h0000);
            chk(audio_format, 16'(i));
            chk(speed_mode, (i == 3) ? dmc_pkg::SPEED_QUAD : (i == 2) ? dmc_pkg::SPEED_DOUBLE
                : dmc_pkg::SPEED_SINGLE);
            chk(deemph_sel, (i == 1) ? dmc_pkg::DEM_44K1 : dmc_pkg::DEM_NONE);
            chk(osr_ratio, (i == 3) ? dmc_pkg::OSR_QUAD : (i == 2) ? dmc_pkg::OSR_DOUBLE
                : dmc_pkg::OSR_SINGLE);
            chk(slow_filter, 16'h0000);
            chk(mute_drive_out, 16'h0000);
        end
        repeat (16) begin
            repeat (4) @(negedge core_clk);
            frame_clk = ~frame_clk;
        end
        repeat (8) @(negedge core_clk);
        chk(volume_atten, 16'h03F8);
        straps = 4'h0;
        do_reset();
        i_dmc_host_model.wr(8'h04, 8'h33);
        i_dmc_host_model.wr(8'h08, 8'hC0);
        chk(port_mode, 16'h0001);
        repeat (WAIT_SIM + 20) @(negedge core_clk);
        chk(powered_up, 16'h0000);
        i_dmc_host_model.rd(8'h04, rd_val);
        chk(rd_val, dmc_pkg::RST_MUTE);
        i_dmc_host_model.rd(8'h07, rd_val);
        chk(rd_val, dmc_pkg::RST_FILT);
        i_dmc_host_model.xfer(1'b1, 1'b0, 8'h82, rd_val);
        i_dmc_host_model.xfer(1'b0, 1'b0, 8'h31, rd_val);
        i_dmc_host_model.xfer(1'b0, 1'b0, 8'h12, rd_val);
        i_dmc_host_model.rd(8'h02, rd_val);
        chk(rd_val, 16'h0031);
        i_dmc_host_model.xfer(1'b0, 1'b1, 8'h00, rd_val);
        chk(rd_val, 16'h0031);
        i_dmc_host_model.rd(8'hF3, rd_val);
        chk(rd_val, 16'h0012);
        i_dmc_host_model.wr(8'h08, 8'h40);
        chk(powered_up, 16'h0001);
        chk(speed_mode, dmc_pkg::SPEED_DOUBLE);
        chk(audio_format, dmc_pkg::FMT_RJ24);
        i_dmc_host_model.wr(8'h02, 8'h83);
        chk(bitstream_mode, 16'h0001);
        chk(bitstream_pin_sel, 16'h0001);
        i_dmc_host_model.wr(8'h07, 8'hB5);
        chk(slow_filter, 16'h0001);
        chk(bitstream_direct, 16'h0001);
        i_dmc_host_model.wr(8'h09, 8'h0F);
        chk(phase_mod_en, 16'h0001);
        chk(phase_mod_clk, 16'h0001);
        chk(stream_fix_en, 16'h0001);
        do_reset();
        i_dmc_host_model.rd(8'h02, rd_val);
        chk(rd_val, dmc_pkg::RST_MODE);
        end_sim();
    end
endmodule
